/* rtl/prim_pkg.sv */
// package for the logic primitive set: reset values, trigger modes, data width
// assumes one clock domain; trigger inputs arrive from pins and are synchronised in the top
package prim_pkg;

	// ----------------------------------------------------------------
	// reset values and modes
	// ----------------------------------------------------------------
	localparam logic TRUE_RST = 1'h0; // true output after reset
	localparam logic COMP_RST = 1'h1; // complement output after reset
	localparam logic MODE_EDGE = 1'h0; // set-reset trigger mode: edge
	localparam logic MODE_LEVEL = 1'h1; // set-reset trigger mode: level
	localparam int DATA_W_DEF = 16; // default data word width
	localparam int SYNC_STAGES = 3; // pin synchroniser depth

	// set-reset storage update kind
	typedef enum logic [1:0] {
		SR_HOLD = 2'b00,
		SR_CLEAR = 2'b01,
		SR_SET = 2'b10
	} sr_act_t;

endpackage

/* rtl/bin_mux.sv */
// binary-coded multiplexer of 2, 4 or 8 registered words
// assumes inputs and select are already in the clk domain
`timescale 1ns/1ps
module bin_mux import prim_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF,
	parameter int SEL_W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// select and data
	input wire logic [SEL_W-1:0] sel,
	input wire logic [(1<<SEL_W)*DATA_W-1:0] data_in,
	// routed word
	output logic [DATA_W-1:0] data_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] y; // registered output word
	} st_t;
	st_t s_q, s_d;

	// route word whose index is the select value, bit zero least significant
	always_comb begin
		s_d = s_q;
		s_d.y = data_in[sel*DATA_W +: DATA_W];
	end

	// register the copy
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_out = s_q.y;

endmodule

/* rtl/pri_mux.sv */
// priority-coded multiplexer with N data inputs and N-1 selects
// assumes inputs and selects are already in the clk domain
`timescale 1ns/1ps
module pri_mux import prim_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF,
	parameter int N_IN = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// select and data
	input wire logic [N_IN-2:0] sel,
	input wire logic [N_IN*DATA_W-1:0] data_in,
	// routed word
	output logic [DATA_W-1:0] data_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] y; // registered output word
	} st_t;
	st_t s_q, s_d;

	// lowest set select wins; scan downward so the lowest is written last
	always_comb begin
		s_d = s_q;
		s_d.y = data_in[(N_IN-1)*DATA_W +: DATA_W];
		for (int i = N_IN-2; i >= 0; i--) begin
			if (sel[i]) begin
				s_d.y = data_in[i*DATA_W +: DATA_W];
			end
		end
	end

	// register the copy
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_out = s_q.y;

endmodule

/* rtl/logic_primitive_set.sv */
// top of the logic primitive set: hold register, muxes, set-reset and j-k flip-flops
// assumes trigger and control pins are asynchronous; they pass three flops each
`timescale 1ns/1ps
module logic_primitive_set import prim_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF,
	parameter logic JK_HAS_SR = 1'h1 // zero: j-k preset/clear pins ignored
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// hold register
	input wire logic sample_ctrl,
	input wire logic [DATA_W-1:0] hold_data,
	output logic [DATA_W-1:0] hold_out,
	// binary multiplexers
	input wire logic select_bit_zero,
	input wire logic select_bit_one,
	input wire logic select_bit_two,
	input wire logic [DATA_W-1:0] data_in_zero,
	input wire logic [DATA_W-1:0] data_in_one,
	input wire logic [DATA_W-1:0] data_in_two,
	input wire logic [DATA_W-1:0] data_in_three,
	input wire logic [DATA_W-1:0] data_in_four,
	input wire logic [DATA_W-1:0] data_in_five,
	input wire logic [DATA_W-1:0] data_in_six,
	input wire logic [DATA_W-1:0] data_in_seven,
	output logic [DATA_W-1:0] bmux2_out,
	output logic [DATA_W-1:0] bmux4_out,
	output logic [DATA_W-1:0] bmux8_out,
	// priority multiplexers
	output logic [DATA_W-1:0] pmux3_out,
	output logic [DATA_W-1:0] pmux4_out,
	// set-reset flip-flop
	input wire logic sr_mode,
	input wire logic sr_set,
	input wire logic sr_reset,
	output logic sr_q,
	output logic sr_q_n,
	// j-k flip-flop
	input wire logic jk_clk,
	input wire logic jk_j,
	input wire logic jk_k,
	input wire logic jk_set_n,
	input wire logic jk_reset_n,
	output logic jk_q,
	output logic jk_q_n
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	// pin order inside the synchroniser bus
	localparam int P_SAMPLE = 0;
	localparam int P_SEL0 = 1;
	localparam int P_SEL1 = 2;
	localparam int P_SEL2 = 3;
	localparam int P_SRMODE = 4;
	localparam int P_SET = 5;
	localparam int P_RST = 6;
	localparam int P_JKCLK = 7;
	localparam int P_J = 8;
	localparam int P_K = 9;
	localparam int P_SN = 10;
	localparam int P_RN = 11;
	localparam int NPIN = 12;
	// idle pin levels: the active-low overrides rest high, so reset must not
	// present them as asserted or the j-k would be forced to 0/0 after reset
	localparam logic [NPIN-1:0] PIN_IDLE = 12'hC00;

	logic [NPIN-1:0] pins; // raw pin levels
	assign pins = {jk_reset_n, jk_set_n, jk_k, jk_j, jk_clk, sr_reset, sr_set, sr_mode,
		select_bit_two, select_bit_one, select_bit_zero, sample_ctrl};

	// per-pin accepted level changes only once the second and third stages agree
	function automatic logic [NPIN-1:0] accept(input logic [NPIN-1:0] s2, input logic [NPIN-1:0] s3,
		input logic [NPIN-1:0] prev);
		accept = (s2 & s3) | (prev & (s2 | s3));
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NPIN-1:0] m1; // first sync stage, read only by m2
		logic [NPIN-1:0] m2; // second stage
		logic [NPIN-1:0] m3; // third stage
		logic [NPIN-1:0] lv; // accepted level
		logic [DATA_W-1:0] hold; // captured word
		logic sr; // set-reset true output
		logic sr_n; // set-reset complement
		logic jk; // j-k true output
		logic jk_n; // j-k complement
	} st_t;
	st_t s_q, s_d;

	logic [NPIN-1:0] lv_new; // accepted level this cycle
	logic [NPIN-1:0] rise; // one-cycle rising edge of accepted level
	logic sn_eff, rn_eff; // effective j-k overrides
	sr_act_t sr_act; // set-reset decision

	// next state of every primitive except the muxes
	always_comb begin
		s_d = s_q;
		s_d.m1 = pins;
		s_d.m2 = s_q.m1;
		s_d.m3 = s_q.m2;
		lv_new = accept(s_q.m2, s_q.m3, s_q.lv);
		s_d.lv = lv_new;
		rise = lv_new & ~s_q.lv;

		// hold register: only a rising sample control captures
		if (rise[P_SAMPLE]) begin
			s_d.hold = hold_data;
		end
		// otherwise hold stays, whatever the data input does

		// set-reset decision by mode
		sr_act = SR_HOLD;
		if (lv_new[P_SRMODE] == MODE_EDGE) begin
			// edge mode: act only on a rising set or reset
			if (rise[P_RST] && !lv_new[P_SET]) begin
				sr_act = SR_CLEAR;
			end else if (rise[P_SET] && !lv_new[P_RST]) begin
				sr_act = SR_SET;
			end
		end else begin
			// level mode: both high is unused, treated as hold
			if (lv_new[P_SET] && !lv_new[P_RST]) begin
				sr_act = SR_SET;
			end else if (lv_new[P_RST] && !lv_new[P_SET]) begin
				sr_act = SR_CLEAR;
			end
		end
		unique case (sr_act)
			SR_SET: begin
				s_d.sr = 1'b1;
				s_d.sr_n = 1'b0;
			end
			SR_CLEAR: begin
				s_d.sr = 1'b0;
				s_d.sr_n = 1'b1;
			end
			SR_HOLD: begin
				s_d.sr = s_q.sr;
			end
			default: begin
				s_d.sr = s_q.sr;
			end
		endcase

		// j-k: the variant without overrides sees them held high
		sn_eff = JK_HAS_SR ? lv_new[P_SN] : 1'b1;
		rn_eff = JK_HAS_SR ? lv_new[P_RN] : 1'b1;
		if (!sn_eff || !rn_eff) begin
			// overrides win over the clock; both low drives both outputs low
			s_d.jk = sn_eff ? 1'b0 : (rn_eff ? 1'b1 : 1'b0);
			s_d.jk_n = rn_eff ? 1'b0 : (sn_eff ? 1'b1 : 1'b0);
		end else if (rise[P_JKCLK]) begin
			unique case ({lv_new[P_J], lv_new[P_K]})
				2'b01: begin
					s_d.jk = 1'b0;
					s_d.jk_n = 1'b1;
				end
				2'b10: begin
					s_d.jk = 1'b1;
					s_d.jk_n = 1'b0;
				end
				2'b11: begin
					s_d.jk = ~s_q.jk;
					s_d.jk_n = s_q.jk;
				end
				2'b00: begin
					s_d.jk = s_q.jk;
				end
			endcase
		end
	end

	// register the copy; reset puts true low, complement high everywhere
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.m1 <= PIN_IDLE;
			s_q.m2 <= PIN_IDLE;
			s_q.m3 <= PIN_IDLE;
			s_q.lv <= PIN_IDLE;
			s_q.sr <= TRUE_RST;
			s_q.sr_n <= COMP_RST;
			s_q.jk <= TRUE_RST;
			s_q.jk_n <= COMP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// multiplexers
	// ----------------------------------------------------------------
	bin_mux #(.DATA_W(DATA_W), .SEL_W(1)) u_bmux2 (
		.clk(clk),
		.rst(rst),
		.sel(s_q.lv[P_SEL0]),
		.data_in({data_in_one, data_in_zero}),
		.data_out(bmux2_out)
	);

	bin_mux #(.DATA_W(DATA_W), .SEL_W(2)) u_bmux4 (
		.clk(clk),
		.rst(rst),
		.sel({s_q.lv[P_SEL1], s_q.lv[P_SEL0]}),
		.data_in({data_in_three, data_in_two, data_in_one, data_in_zero}),
		.data_out(bmux4_out)
	);

	bin_mux #(.DATA_W(DATA_W), .SEL_W(3)) u_bmux8 (
		.clk(clk),
		.rst(rst),
		.sel({s_q.lv[P_SEL2], s_q.lv[P_SEL1], s_q.lv[P_SEL0]}),
		.data_in({data_in_seven, data_in_six, data_in_five, data_in_four,
			data_in_three, data_in_two, data_in_one, data_in_zero}),
		.data_out(bmux8_out)
	);

	pri_mux #(.DATA_W(DATA_W), .N_IN(3)) u_pmux3 (
		.clk(clk),
		.rst(rst),
		.sel({s_q.lv[P_SEL1], s_q.lv[P_SEL0]}),
		.data_in({data_in_two, data_in_one, data_in_zero}),
		.data_out(pmux3_out)
	);

	pri_mux #(.DATA_W(DATA_W), .N_IN(4)) u_pmux4 (
		.clk(clk),
		.rst(rst),
		.sel({s_q.lv[P_SEL2], s_q.lv[P_SEL1], s_q.lv[P_SEL0]}),
		.data_in({data_in_three, data_in_two, data_in_one, data_in_zero}),
		.data_out(pmux4_out)
	);

	// flop outputs
	assign hold_out = s_q.hold;
	assign sr_q = s_q.sr;
	assign sr_q_n = s_q.sr_n;
	assign jk_q = s_q.jk;
	assign jk_q_n = s_q.jk_n;

endmodule

/* testbench/prim_checker.sv */
// checker for the logic primitive set: assertions on the top ports
// assumes pins are held six cycles or more by the surrounding control logic
`timescale 1ns/1ps
module prim_checker import prim_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF,
	parameter logic JK_HAS_SR = 1'h1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// hold register
	input wire logic sample_ctrl,
	input wire logic [DATA_W-1:0] hold_data, hold_out,
	// muxes
	input wire logic select_bit_zero, select_bit_one, select_bit_two,
	input wire logic [DATA_W-1:0] data_in_zero, data_in_one, data_in_two, data_in_three,
	input wire logic [DATA_W-1:0] data_in_four, data_in_five, data_in_six, data_in_seven,
	input wire logic [DATA_W-1:0] bmux4_out, bmux8_out, pmux4_out,
	// flip-flops
	input wire logic sr_mode, sr_set, sr_reset, sr_q, sr_q_n,
	input wire logic jk_set_n, jk_reset_n, jk_q, jk_q_n
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] d [8]; // mux words by index
	logic [8*DATA_W+2:0] mux_in; // all mux inputs, for stability tests
	// gather words; selects sit in the low bits
	always_comb begin
		d = '{data_in_zero, data_in_one, data_in_two, data_in_three,
			data_in_four, data_in_five, data_in_six, data_in_seven};
		mux_in = {data_in_zero, data_in_one, data_in_two, data_in_three, data_in_four,
			data_in_five, data_in_six, data_in_seven, select_bit_two, select_bit_one, select_bit_zero};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_hold_capture: assert property (((!sample_ctrl)[*4] ##1 (sample_ctrl && $stable(hold_data))[*6])
		|=> hold_out == $past(hold_data)) else $error("hold missed capture");
	a_hold_keep: assert property ((!sample_ctrl)[*8] |=> $stable(hold_out))
		else $error("hold changed without capture");
	a_bmux4_route: assert property ($stable(mux_in)[*7] |=> bmux4_out == $past(d[{select_bit_one, select_bit_zero}]))
		else $error("bmux4 wrong word");
	a_bmux8_route: assert property ($stable(mux_in)[*7]
		|=> bmux8_out == $past(d[{select_bit_two, select_bit_one, select_bit_zero}]))
		else $error("bmux8 wrong word");
	a_pmux4_prio: assert property ($stable(mux_in)[*7] |=> pmux4_out == $past(select_bit_zero ? d[0] :
		select_bit_one ? d[1] : select_bit_two ? d[2] : d[3])) else $error("pmux4 wrong word");
	a_sr_pair: assert property (sr_q_n == !sr_q) else $error("sr outputs not complementary");
	a_sr_level_set: assert property ((sr_mode && sr_set && !sr_reset)[*5] |=> sr_q)
		else $error("sr level set failed");
	a_sr_hold: assert property ((!sr_set && !sr_reset)[*6] |=> $stable(sr_q))
		else $error("sr changed while idle");
	a_jk_preset: assert property ((JK_HAS_SR && !jk_set_n && jk_reset_n)[*5] |=> jk_q && !jk_q_n)
		else $error("jk preset failed");
	a_jk_both_low: assert property ((JK_HAS_SR && !jk_set_n && !jk_reset_n)[*5] |=> !jk_q && !jk_q_n)
		else $error("jk both overrides failed");
	a_reset_vals: assert property (disable iff (1'b0) rst |=> !sr_q && sr_q_n && !jk_q && jk_q_n && hold_out == '0)
		else $error("reset values wrong");
endmodule
bind logic_primitive_set prim_checker #(.DATA_W(DATA_W), .JK_HAS_SR(JK_HAS_SR)) chk_u (.*);

/* testbench/ctrl_src.sv */
// surrounding control logic: drives trigger, select and override pins
// assumes a free-running clk; pins change only on its falling edge
`timescale 1ns/1ps
module ctrl_src (
	// clock
	input wire logic clk,
	// pin levels, bit order given in the bench
	output logic [11:0] pins
);
	// overrides start inactive high, all else low
	initial pins = 12'h003;
	// ----------------------------------------------------------------
	// one pin step, then a six-cycle hold
	// ----------------------------------------------------------------
	task automatic step(input logic [11:0] v);
		logic [11:0] w;
		w = v;
		// set and reset never high together: those rows are unused
		if (w[6] && w[5]) begin
			w[5] = 1'b0;
		end
		@(negedge clk);
		pins <= w;
		// six cycles clear the two-cycle minimum pulse width
		repeat (6) @(negedge clk);
	endtask
endmodule

/* testbench/logic_primitive_set_bench.sv */
// self-checking bench for the logic primitive set
// assumes the package, design, ctrl_src and checker are compiled first
`timescale 1ns/1ps
module logic_primitive_set_bench;
	localparam int W = 12; // not the default width: words pass whole
	logic clk = 1'b0; // 25 MHz clock
	logic rst = 1'b1; // held five cycles
	logic [W-1:0] hd = '0; // word offered to hold
	logic [W-1:0] dw [8]; // mux words
	logic [W-1:0] ho, b2, b4, b8, p3, p4; // word outputs
	logic sq, sqn, jq, jqn; // flip-flop outputs
	logic [11:0] pins; // pins from the control model
	int num_errors = 0;
	int total_checks = 0;
	// clock, 40 ns period
	always #20 clk = ~clk;
	// distinct words, upper bits set for words zero to five
	initial for (int i = 0; i < 8; i++) dw[i] = W'(12'hA05 + 12'h111 * i);
	ctrl_src ctrl_u (.clk(clk), .pins(pins));
	logic_primitive_set #(.DATA_W(W)) dut_u (.clk(clk), .rst(rst),
		.sample_ctrl(pins[11]), .hold_data(hd), .hold_out(ho),
		.select_bit_zero(pins[8]), .select_bit_one(pins[9]), .select_bit_two(pins[10]),
		.data_in_zero(dw[0]), .data_in_one(dw[1]), .data_in_two(dw[2]), .data_in_three(dw[3]),
		.data_in_four(dw[4]), .data_in_five(dw[5]), .data_in_six(dw[6]), .data_in_seven(dw[7]),
		.bmux2_out(b2), .bmux4_out(b4), .bmux8_out(b8), .pmux3_out(p3), .pmux4_out(p4),
		.sr_mode(pins[7]), .sr_set(pins[6]), .sr_reset(pins[5]), .sr_q(sq), .sr_q_n(sqn),
		.jk_clk(pins[4]), .jk_j(pins[3]), .jk_k(pins[2]), .jk_set_n(pins[1]), .jk_reset_n(pins[0]),
		.jk_q(jq), .jk_q_n(jqn));
	// ----------------------------------------------------------------
	// compare and verdict
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [W-1:0] exp, input logic [W-1:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("hold_rst", '0, ho);
		chk("sr_rst", 12'h001, W'({sq, sqn}));
		chk("jk_rst", 12'h001, W'({jq, jqn}));
	endtask
	// data changes while control is high, then control falls
	task automatic t_hold();
		hd = 12'h5A3;
		ctrl_u.step(12'h803);
		chk("hold_cap", 12'h5A3, ho);
		hd = 12'h0C6;
		ctrl_u.step(12'h003);
		chk("hold_keep", 12'h5A3, ho);
		ctrl_u.step(12'h803);
		chk("hold_new", 12'h0C6, ho);
		ctrl_u.step(12'h003);
	endtask
	// every select code through every mux
	task automatic t_mux();
		logic [2:0] s;
		for (int i = 0; i < 8; i++) begin
			s = 3'(i);
			// fresh words each pass so every data input is exercised, not tied
			for (int k = 0; k < 8; k++) begin
				dw[k] = W'(12'hA05 + 12'h111 * k + 12'h013 * i);
			end
			ctrl_u.step({1'b0, s, 8'h03});
			chk("bmux8", dw[s], b8);
			chk("bmux4", dw[s[1:0]], b4);
			chk("bmux2", dw[s[0]], b2);
			chk("pmux4", s[0] ? dw[0] : s[1] ? dw[1] : s[2] ? dw[2] : dw[3], p4);
			chk("pmux3", s[0] ? dw[0] : s[1] ? dw[1] : dw[2], p3);
		end
	endtask
	// edge mode, then level mode
	task automatic t_sr();
		ctrl_u.step(12'h043);
		chk("sr_edge_set", 12'h002, W'({sq, sqn}));
		ctrl_u.step(12'h003);
		chk("sr_edge_keep", 12'h002, W'({sq, sqn}));
		ctrl_u.step(12'h023);
		chk("sr_edge_clr", 12'h001, W'({sq, sqn}));
		ctrl_u.step(12'h003);
		ctrl_u.step(12'h0C3);
		chk("sr_lvl_set", 12'h002, W'({sq, sqn}));
		ctrl_u.step(12'h083);
		chk("sr_lvl_keep", 12'h002, W'({sq, sqn}));
		ctrl_u.step(12'h0A3);
		chk("sr_lvl_clr", 12'h001, W'({sq, sqn}));
		ctrl_u.step(12'h003);
	endtask
	// clocked j-k codes, then the overrides
	task automatic t_jk();
		logic [1:0] jk [6] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b11, 2'b10};
		logic q;
		q = 1'b0;
		for (int i = 0; i < 6; i++) begin
			ctrl_u.step({7'h00, 1'b0, jk[i], 2'b11});
			ctrl_u.step({7'h00, 1'b1, jk[i], 2'b11});
			q = jk[i] == 2'b11 ? ~q : jk[i] == 2'b00 ? q : jk[i][1];
			chk("jk_clk", W'({q, ~q}), W'({jq, jqn}));
		end
		ctrl_u.step(12'h002);
		chk("jk_clr_n", 12'h001, W'({jq, jqn}));
		ctrl_u.step(12'h001);
		chk("jk_set_n", 12'h002, W'({jq, jqn}));
		ctrl_u.step(12'h015);
		chk("jk_ovr_clk", 12'h002, W'({jq, jqn}));
		ctrl_u.step(12'h000);
		chk("jk_both_n", 12'h000, W'({jq, jqn}));
		ctrl_u.step(12'h003);
	endtask
	// main sequence
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_hold();
		t_mux();
		t_sr();
		t_jk();
		summarize();
	end
	// watchdog: the run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule
